// file: bsrm_pkg.sv
// Package for the bank switched RAM mapper: address map, control layout, register map.
// Assumes one clock domain; the processor bus and the register bus run on mclk.
package bsrm_pkg;

    // Processor address regions (upper nibble / byte boundaries)
    localparam logic [15:0] IO_PAGE_BASE   = 16'hc000;
    localparam logic [15:0] SLOT_ROM_BASE  = 16'hc100;
    localparam logic [15:0] D_REGION_BASE  = 16'hd000;
    localparam logic [15:0] EF_REGION_BASE = 16'he000;

    // Control addresses occupy $C080..$C08F; the low nibble selects the action
    localparam logic [11:0] CTRL_PAGE_HI   = 12'hc08;

    // Position of the control address bit that decodes the bank, and of the SRAM address bits set by the mapping
    localparam int ADDR_BANK_BIT  = 3;
    localparam int SRAM_HI_BIT    = 16;
    localparam int SRAM_BANK_BIT  = 12;

    // Low two bits of a control address
    localparam logic [1:0] CTRL_RAM_RD_NOWR = 2'h0;
    localparam logic [1:0] CTRL_ROM_RD_WR   = 2'h1;
    localparam logic [1:0] CTRL_ROM_RD_NOWR = 2'h2;
    localparam logic [1:0] CTRL_RAM_RD_WR   = 2'h3;

    // Four-bit control register
    typedef struct packed {
        logic delay;   // Write enable pre-arm after one odd read
        logic wr_ram;  // Expansion RAM writes enabled
        logic bank;    // High: first bank of $Dxxx
        logic rd_ram;  // Upper-region reads from expansion RAM
    } bsrm_ctrl_t;

    localparam bsrm_ctrl_t CTRL_RESET = '{delay: 1'b0, wr_ram: 1'b0, bank: 1'b0, rd_ram: 1'b0};

    // One processor access per cycle at most
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
    } bsrm_cpu_req_t;

    typedef enum logic [2:0] {RG_LOW, RG_IO, RG_SLOT, RG_D, RG_EF} bsrm_region_t;

    // Register bus map (byte addresses)
    localparam logic [7:0] REG_CONFIG    = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_LAST_MAP  = 8'h08;
    localparam int         CFG_ENABLE_BIT = 0;
    localparam int         CFG_CLEAR_BIT  = 1;
    localparam logic       CFG_ENABLE_RESET = 1'b1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

endpackage : bsrm_pkg

// file: bsrm_mapper.sv
// Bank switched 16 KB RAM mapper: control register set by processor reads,
// 16-bit to 17-bit SRAM address translation, AHB-Lite register slave.
// Assumes the processor core and the AHB-Lite master share mclk; one access per cycle.

module bsrm_mapper (
    input  wire logic                   mclk,
    input  wire logic                   srst,
    input  wire bsrm_pkg::bsrm_cpu_req_t cpu_req,
    output logic [16:0]                 sram_addr_line,
    output logic                        sram_sel,
    output logic                        sram_we,
    output logic                        io_sel,
    output bsrm_pkg::bsrm_ctrl_t        ctrl_out,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp
);

    function automatic bsrm_pkg::bsrm_region_t region_of(input logic [15:0] a);
        if (a < bsrm_pkg::IO_PAGE_BASE)
            return bsrm_pkg::RG_LOW;
        else if (a < bsrm_pkg::SLOT_ROM_BASE)
            return bsrm_pkg::RG_IO;
        else if (a < bsrm_pkg::D_REGION_BASE)
            return bsrm_pkg::RG_SLOT;
        else if (a < bsrm_pkg::EF_REGION_BASE)
            return bsrm_pkg::RG_D;
        else
            return bsrm_pkg::RG_EF;
    endfunction : region_of

    function automatic logic is_ctrl(input logic [15:0] a);
        return a[15:4] == bsrm_pkg::CTRL_PAGE_HI;
    endfunction : is_ctrl

    bsrm_pkg::bsrm_ctrl_t  ctrl_reg;
    bsrm_pkg::bsrm_ctrl_t  ctrl_next;
    logic                  card_en_reg;
    logic                  wr_pend_reg;
    logic [7:0]            wr_addr_reg;
    logic [16:0]           sram_addr_reg;
    logic                  sram_sel_reg;
    logic                  sram_we_reg;
    logic                  io_sel_reg;
    logic [31:0]           hrdata_reg;
    logic                  soft_clr;
    logic                  ctrl_rd;
    logic                  ctrl_wr;
    logic                  odd_addr;
    bsrm_pkg::bsrm_region_t reg_now;
    logic                  use_ram;
    logic [16:0]           sram_addr_next;
    logic                  sram_sel_next;
    logic                  sram_we_next;
    logic                  ahb_take;

    // ---------------- Register bus slave ----------------
    assign ahb_take = hsel && hready && (htrans == bsrm_pkg::HTRANS_NONSEQ);
    assign soft_clr = wr_pend_reg && (wr_addr_reg == bsrm_pkg::REG_CONFIG) && hwdata[bsrm_pkg::CFG_CLEAR_BIT];

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else if (hready) begin
            wr_pend_reg <= ahb_take && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            card_en_reg <= bsrm_pkg::CFG_ENABLE_RESET;
        end else if (wr_pend_reg && wr_addr_reg == bsrm_pkg::REG_CONFIG) begin
            card_en_reg <= hwdata[bsrm_pkg::CFG_ENABLE_BIT];
        end
    end

    // Read data is prepared in the address phase so no wait states are needed
    always_ff @(posedge mclk) begin
        if (srst) begin
            hrdata_reg <= bsrm_pkg::RDATA_ZERO;
        end else if (ahb_take && !hwrite) begin
            unique case (haddr[7:0])
                bsrm_pkg::REG_CONFIG:   hrdata_reg <= {31'h0000_0000, card_en_reg};
                bsrm_pkg::REG_STATUS:   hrdata_reg <= {28'h000_0000, ctrl_reg};
                bsrm_pkg::REG_LAST_MAP: hrdata_reg <= {12'h000, sram_we_reg, sram_sel_reg, io_sel_reg, sram_addr_reg};
                default:                hrdata_reg <= bsrm_pkg::RDATA_ZERO;
            endcase
        end
    end

    // ---------------- Control register ----------------
    assign ctrl_rd  = cpu_req.rd && is_ctrl(cpu_req.addr) && card_en_reg;
    assign ctrl_wr  = cpu_req.wr && is_ctrl(cpu_req.addr) && card_en_reg;
    assign odd_addr = cpu_req.addr[0];

    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_rd) begin
            ctrl_next.bank   = cpu_req.addr[bsrm_pkg::ADDR_BANK_BIT];
            unique case (cpu_req.addr[1:0])
                bsrm_pkg::CTRL_RAM_RD_NOWR: ctrl_next.rd_ram = 1'b1;
                bsrm_pkg::CTRL_ROM_RD_WR:   ctrl_next.rd_ram = 1'b0;
                bsrm_pkg::CTRL_ROM_RD_NOWR: ctrl_next.rd_ram = 1'b0;
                bsrm_pkg::CTRL_RAM_RD_WR:   ctrl_next.rd_ram = 1'b1;
            endcase
            if (odd_addr) begin
                // Writes open only on the second consecutive odd read
                ctrl_next.wr_ram = ctrl_reg.wr_ram || ctrl_reg.delay;
                ctrl_next.delay  = 1'b1;
            end else begin
                ctrl_next.wr_ram = 1'b0;
                ctrl_next.delay  = 1'b0;
            end
        end else if (ctrl_wr) begin
            // A write between the two reads breaks the sequence
            ctrl_next.delay = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge srst) begin
        if (srst) begin
            ctrl_reg <= bsrm_pkg::CTRL_RESET;
        end else if (soft_clr) begin
            ctrl_reg <= bsrm_pkg::CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ---------------- Address translation ----------------
    assign reg_now = region_of(cpu_req.addr);

    always_comb begin
        use_ram        = 1'b0;
        sram_addr_next = {1'b0, cpu_req.addr};
        sram_sel_next  = 1'b0;
        sram_we_next   = 1'b0;
        unique case (reg_now)
            bsrm_pkg::RG_LOW: begin
                sram_sel_next = cpu_req.rd || cpu_req.wr;
                sram_we_next  = cpu_req.wr;
            end
            bsrm_pkg::RG_IO: begin
                sram_sel_next = 1'b0;
            end
            bsrm_pkg::RG_SLOT: begin
                sram_sel_next = cpu_req.rd;
            end
            bsrm_pkg::RG_D, bsrm_pkg::RG_EF: begin
                use_ram = card_en_reg && ((cpu_req.rd && ctrl_reg.rd_ram) ||
                                          (cpu_req.wr && ctrl_reg.wr_ram));
                sram_addr_next[bsrm_pkg::SRAM_HI_BIT] = use_ram;
                if (reg_now == bsrm_pkg::RG_D && use_ram && ctrl_reg.bank) begin
                    sram_addr_next[bsrm_pkg::SRAM_BANK_BIT] = 1'b0;
                end
                sram_sel_next = cpu_req.rd || use_ram;
                sram_we_next  = cpu_req.wr && use_ram;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            sram_addr_reg <= '0;
            sram_sel_reg  <= 1'b0;
            sram_we_reg   <= 1'b0;
            io_sel_reg    <= 1'b0;
        end else begin
            sram_addr_reg <= sram_addr_next;
            sram_sel_reg  <= sram_sel_next;
            sram_we_reg   <= sram_we_next;
            io_sel_reg    <= (reg_now == bsrm_pkg::RG_IO) && (cpu_req.rd || cpu_req.wr);
        end
    end

    assign sram_addr_line = sram_addr_reg;
    assign sram_sel       = sram_sel_reg;
    assign sram_we        = sram_we_reg;
    assign io_sel         = io_sel_reg;
    assign ctrl_out       = ctrl_reg;
    assign hrdata         = hrdata_reg;
    assign hreadyout      = 1'b1;
    assign hresp          = bsrm_pkg::HRESP_OKAY;

    // ---------------- Checks ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    logic clean_rd;
    logic any_acc;
    assign clean_rd = ctrl_rd && !soft_clr;
    assign any_acc  = cpu_req.rd || cpu_req.wr;

    chk_read_ram_nowr: assert property (
        clean_rd && cpu_req.addr[1:0] == bsrm_pkg::CTRL_RAM_RD_NOWR |=> ctrl_reg.rd_ram && !ctrl_reg.wr_ram)
        else $error("RAM-read control access left wrong mode");

    chk_read_rom_wr: assert property (
        clean_rd && cpu_req.addr[1:0] == bsrm_pkg::CTRL_ROM_RD_WR |=> !ctrl_reg.rd_ram && ctrl_reg.delay)
        else $error("ROM-read write-arm access left wrong mode");

    chk_read_rom_nowr: assert property (
        clean_rd && cpu_req.addr[1:0] == bsrm_pkg::CTRL_ROM_RD_NOWR |=> !ctrl_reg.rd_ram && !ctrl_reg.wr_ram)
        else $error("ROM-read no-write access left wrong mode");

    chk_read_ram_wr: assert property (
        clean_rd && cpu_req.addr[1:0] == bsrm_pkg::CTRL_RAM_RD_WR |=> ctrl_reg.rd_ram && ctrl_reg.delay)
        else $error("RAM-read write-arm access left wrong mode");

    chk_bank_follows: assert property (
        clean_rd |=> ctrl_reg.bank == $past(cpu_req.addr[bsrm_pkg::ADDR_BANK_BIT]))
        else $error("Bank bit does not follow control address");

    chk_single_odd: assert property (
        clean_rd && odd_addr && !ctrl_reg.delay && !ctrl_reg.wr_ram |=> !ctrl_reg.wr_ram)
        else $error("Write enable set after a single odd read");

    chk_double_odd: assert property (
        clean_rd && odd_addr ##1 clean_rd && odd_addr |=> ctrl_reg.wr_ram)
        else $error("Two odd reads did not enable writes");

    chk_low_passthru: assert property (
        any_acc && cpu_req.addr < bsrm_pkg::IO_PAGE_BASE |=> sram_sel && sram_addr_line == {1'b0, $past(cpu_req.addr)})
        else $error("Low region not mapped unchanged");

    chk_io_nosel: assert property (
        any_acc && region_of(cpu_req.addr) == bsrm_pkg::RG_IO |=> io_sel && !sram_sel && !sram_we)
        else $error("I/O page selected SRAM");

    chk_slot_nowrite: assert property (
        region_of(cpu_req.addr) == bsrm_pkg::RG_SLOT |=> !sram_we && !sram_addr_line[bsrm_pkg::SRAM_HI_BIT])
        else $error("Slot ROM space written or moved");

    chk_bits_kept: assert property (
        any_acc |=> sram_addr_line[15:13] == $past(cpu_req.addr[15:13]) &&
                    sram_addr_line[11:0] == $past(cpu_req.addr[11:0]))
        else $error("SRAM address bits other than 16 and 12 altered");

    chk_bank_high_d: assert property (
        cpu_req.rd && region_of(cpu_req.addr) == bsrm_pkg::RG_D && ctrl_reg.rd_ram && ctrl_reg.bank && card_en_reg
        |=> sram_addr_line[bsrm_pkg::SRAM_HI_BIT] && !sram_addr_line[bsrm_pkg::SRAM_BANK_BIT])
        else $error("High bank not mapped to 1Cxxx");

    chk_ef_ram: assert property (
        cpu_req.wr && region_of(cpu_req.addr) == bsrm_pkg::RG_EF && ctrl_reg.wr_ram && card_en_reg
        |=> sram_we && sram_addr_line[bsrm_pkg::SRAM_HI_BIT])
        else $error("Upper region write missed expansion RAM");

    chk_rom_nowrite: assert property (
        cpu_req.wr && !ctrl_reg.wr_ram && cpu_req.addr >= bsrm_pkg::D_REGION_BASE |=> !sram_we)
        else $error("ROM written while writes disabled");

    chk_card_off: assert property (
        !card_en_reg && any_acc && cpu_req.addr >= bsrm_pkg::D_REGION_BASE
        |=> !sram_we && !sram_addr_line[bsrm_pkg::SRAM_HI_BIT])
        else $error("Disabled card still reached expansion RAM");

    chk_low_write: assert property (
        cpu_req.wr && cpu_req.addr < bsrm_pkg::IO_PAGE_BASE |=> sram_we && sram_sel)
        else $error("Low region write not passed to SRAM");

    chk_slot_read: assert property (
        cpu_req.rd && region_of(cpu_req.addr) == bsrm_pkg::RG_SLOT
        |=> sram_sel && sram_addr_line == {1'b0, $past(cpu_req.addr)})
        else $error("Slot ROM read not mapped unchanged");

    chk_d_rom_map: assert property (
        cpu_req.rd && region_of(cpu_req.addr) == bsrm_pkg::RG_D && !(card_en_reg && ctrl_reg.rd_ram)
        |=> sram_sel && !sram_we && sram_addr_line == {1'b0, $past(cpu_req.addr)})
        else $error("ROM view of D region moved");

    chk_bank_low_d: assert property (
        cpu_req.rd && region_of(cpu_req.addr) == bsrm_pkg::RG_D && ctrl_reg.rd_ram && !ctrl_reg.bank && card_en_reg
        |=> sram_addr_line == {1'b1, $past(cpu_req.addr)})
        else $error("Low bank not mapped to 1Dxxx");

    chk_ef_rom_map: assert property (
        cpu_req.rd && region_of(cpu_req.addr) == bsrm_pkg::RG_EF && !(card_en_reg && ctrl_reg.rd_ram)
        |=> sram_sel && sram_addr_line == {1'b0, $past(cpu_req.addr)})
        else $error("ROM view of upper region moved");

    chk_ef_ram_read: assert property (
        cpu_req.rd && region_of(cpu_req.addr) == bsrm_pkg::RG_EF && ctrl_reg.rd_ram && card_en_reg
        |=> sram_sel && sram_addr_line == {1'b1, $past(cpu_req.addr)})
        else $error("Upper region read missed expansion RAM");

    chk_split_access: assert property (
        cpu_req.wr && cpu_req.addr >= bsrm_pkg::D_REGION_BASE && !ctrl_reg.rd_ram && ctrl_reg.wr_ram && card_en_reg
        |=> sram_we && sram_sel && sram_addr_line[bsrm_pkg::SRAM_HI_BIT])
        else $error("Write under ROM reads missed expansion RAM");

    chk_ctrl_kept: assert property (
        !ctrl_rd && !soft_clr |=> $stable(ctrl_out[2:0]))
        else $error("Control bits changed without a control read");

    chk_write_breaks: assert property (
        ctrl_wr && !soft_clr |=> !ctrl_out.delay)
        else $error("Control write left the delay bit set");

    chk_even_clear: assert property (
        clean_rd && !odd_addr |=> !ctrl_out.delay && !ctrl_out.wr_ram)
        else $error("Even control read left writes armed");

    cov_write_arm: cover property (clean_rd && odd_addr ##1 clean_rd && odd_addr ##1 ctrl_reg.wr_ram);
    cov_rom_rd_ram_wr: cover property (!ctrl_reg.rd_ram && ctrl_reg.wr_ram && cpu_req.wr &&
                                       cpu_req.addr >= bsrm_pkg::D_REGION_BASE);
    cov_bank_switch: cover property (ctrl_reg.bank ##[1:20] !ctrl_reg.bank);
    cov_soft_clear: cover property (soft_clr && ctrl_reg.wr_ram);
    cov_ef_ram_read: cover property (cpu_req.rd && ctrl_reg.rd_ram && cpu_req.addr >= bsrm_pkg::EF_REGION_BASE);

endmodule : bsrm_mapper

// file: bsrm_cpu_model.sv
// Processor model for the mapper's processor port: single-cycle reads and writes.
// Assumes the mapper takes an access on the rising edge where rd or wr is high.
module bsrm_cpu_model (
    input  wire logic               mclk,
    output bsrm_pkg::bsrm_cpu_req_t cpu_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cpu_req = '{addr: 16'h0000, rd: 1'b0, wr: 1'b0};

    // Holds one access for n cycles, so n of 2 gives back-to-back reads
    task automatic acc(input logic [15:0] a, input logic r, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            cpu_req <= '{addr: a, rd: r, wr: !r};
        end
        @(posedge mclk);
        // Idle with a changed address so a stale address never matches
        cpu_req <= '{addr: ~a, rd: 1'b0, wr: 1'b0};
        #1;
    endtask : acc
endmodule : bsrm_cpu_model

// file: bsrm_mapper_tb.sv
// Self-checking bench for the bank switched RAM mapper.
// Assumes one clock; registers are reached over AHB-Lite with zero wait states.
module bsrm_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    mclk;
    logic                    srst;
    logic                    hsel;
    logic                    hwrite;
    logic                    hreadyout;
    logic                    hresp;
    logic                    sram_sel;
    logic                    sram_we;
    logic                    io_sel;
    logic                    ex_rd;
    logic                    ex_wr;
    logic [1:0]              htrans;
    logic [2:0]              hsize;
    logic [15:0]             ctl_a;
    logic [16:0]             sram_addr_line;
    logic [31:0]             haddr;
    logic [31:0]             hwdata;
    logic [31:0]             hrdata;
    logic [31:0]             rd_val;
    bsrm_pkg::bsrm_cpu_req_t cpu_req;
    bsrm_pkg::bsrm_ctrl_t    ctrl_out;
    int                      err_count = 0;
    int                      checked = 0;

    bsrm_mapper dut (.mclk(mclk), .srst(srst), .cpu_req(cpu_req), .sram_addr_line(sram_addr_line),
        .sram_sel(sram_sel), .sram_we(sram_we), .io_sel(io_sel), .ctrl_out(ctrl_out), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

    bsrm_cpu_model cpu (.mclk(mclk), .cpu_req(cpu_req));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    // Address is only compared while the SRAM is selected
    task automatic chk_map(input logic [16:0] a, input logic s, input logic w, input logic io);
        cmp("map", {12'h0, io, w, s, s ? a : 17'h0},
            {12'h0, io_sel, sram_we, sram_sel, s ? sram_addr_line : 17'h0});
    endtask : chk_map

    task automatic wait_rdy();
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 20) begin
            err_count++;
            $display("ERROR hready expected 1 seen %b", hreadyout);
            close_out();
        end
    endtask : wait_rdy

    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= bsrm_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        cmp("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb

    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        cmp("ctrl_out", 32'h0, {28'h0, ctrl_out});
        chk_map(17'h0, 1'b0, 1'b0, 1'b0);
        ahb(bsrm_pkg::REG_STATUS, 1'b0, 32'h0, rd_val);
        cmp("status", 32'h0, rd_val);
        $display("Test reset done");
        cpu.acc(16'h1234, 1'b1, 1);
        chk_map(17'h01234, 1'b1, 1'b0, 1'b0);
        cpu.acc(16'hbfff, 1'b0, 1);
        chk_map(17'h0bfff, 1'b1, 1'b1, 1'b0);
        cpu.acc(16'hc050, 1'b1, 1);
        chk_map(17'h0, 1'b0, 1'b0, 1'b1);
        cpu.acc(16'hc100, 1'b1, 1);
        chk_map(17'h0c100, 1'b1, 1'b0, 1'b0);
        cpu.acc(16'hcfff, 1'b0, 1);
        chk_map(17'h0, 1'b0, 1'b0, 1'b0);
        $display("Test regions done");
        for (int k = 0; k < 8; k++) begin
            ctl_a = {12'hc08, k[2], 1'b0, k[1:0]};
            ex_rd = (ctl_a[1:0] == bsrm_pkg::CTRL_RAM_RD_NOWR) || (ctl_a[1:0] == bsrm_pkg::CTRL_RAM_RD_WR);
            ex_wr = ctl_a[0];
            cpu.acc(16'hc082, 1'b1, 1);
            cpu.acc(ctl_a, 1'b1, 1);
            cmp("ctrl_out", {28'h0, ctl_a[0], 1'b0, ctl_a[3], ex_rd}, {28'h0, ctrl_out});
            cpu.acc(ctl_a, 1'b1, 1);
            cmp("ctrl_out", {29'h0, ex_wr, ctl_a[3], ex_rd}, {29'h0, ctrl_out[2:0]});
            ahb(bsrm_pkg::REG_STATUS, 1'b0, 32'h0, rd_val);
            cmp("status", {29'h0, ex_wr, ctl_a[3], ex_rd}, {29'h0, rd_val[2:0]});
            cpu.acc(16'hd123, 1'b1, 1);
            chk_map(ex_rd ? (ctl_a[3] ? 17'h1c123 : 17'h1d123) : 17'h0d123, 1'b1, 1'b0, 1'b0);
            cpu.acc(16'hf000, 1'b1, 1);
            chk_map(ex_rd ? 17'h1f000 : 17'h0f000, 1'b1, 1'b0, 1'b0);
            cpu.acc(16'he456, 1'b0, 1);
            chk_map(17'h1e456, ex_wr, ex_wr, 1'b0);
            cpu.acc(16'hd456, 1'b0, 1);
            chk_map(ctl_a[3] ? 17'h1c456 : 17'h1d456, ex_wr, ex_wr, 1'b0);
        end
        $display("Test control table done");
        cpu.acc(16'hc082, 1'b1, 1);
        cpu.acc(16'hc081, 1'b1, 1);
        cpu.acc(16'hc081, 1'b0, 1);
        cpu.acc(16'hc081, 1'b1, 1);
        cmp("ctrl_out", 32'h0, {31'h0, ctrl_out.wr_ram});
        cpu.acc(16'hc080, 1'b1, 1);
        cpu.acc(16'hc08b, 1'b1, 2);
        cmp("ctrl_out", 32'h7, {29'h0, ctrl_out[2:0]});
        @(posedge mclk);
        srst <= 1'b1;
        #1;
        cmp("ctrl_out", 32'h0, {28'h0, ctrl_out});
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        $display("Test write enable sequence done");
        ahb(bsrm_pkg::REG_CONFIG, 1'b1, 32'h0, rd_val);
        cpu.acc(16'hc08b, 1'b1, 2);
        cmp("ctrl_out", 32'h0, {28'h0, ctrl_out});
        cpu.acc(16'hd123, 1'b1, 1);
        chk_map(17'h0d123, 1'b1, 1'b0, 1'b0);
        ahb(bsrm_pkg::REG_LAST_MAP, 1'b0, 32'h0, rd_val);
        cmp("last_map", 32'h0000_2edc, rd_val);
        ahb(bsrm_pkg::REG_CONFIG, 1'b1, 32'h1, rd_val);
        cpu.acc(16'hc083, 1'b1, 2);
        ahb(bsrm_pkg::REG_CONFIG, 1'b1, 32'h3, rd_val);
        @(posedge mclk);
        #1;
        cmp("ctrl_out", 32'h0, {28'h0, ctrl_out});
        ahb(bsrm_pkg::REG_CONFIG, 1'b0, 32'h0, rd_val);
        cmp("config", 32'h1, rd_val);
        ahb(8'h40, 1'b0, 32'h0, rd_val);
        cmp("unmapped", 32'h0, rd_val);
        $display("Test register bus done");
        close_out();
    end
endmodule : bsrm_mapper_tb
